// [design/pcac_array.v]
// counter array top: 16-bit counter, snapshot, register decode, six channels
// Functional notes
// - counter bits 7..0 are a read/write byte register resetting to zero.
// - counter bits 15..8 are a separate read/write byte register resetting to zero.
// - the high-byte register reads a snapshot refreshed only when the low byte is read.
// - the counter bytes sit on page 0x10 at 0xf9 (low) and 0xfa (high).
// - each channel keeps a 16-bit capture value whose low byte is read/write.
// - each channel's capture high byte is read/write and resets to zero.
// - channel 6..11 low bytes sit at 0xfb, 0xe9, 0xeb, 0xed, 0xfd, 0xce on page 0x10.
// - channel 6..11 high bytes sit at 0xfc, 0xea, 0xec, 0xee, 0xfe, 0xcf on page 0x10.
// - the reload access select steers both channel addresses to the auto-reload value.
// - a write to a channel low byte clears that channel's compare enable.
// - a write to a channel high byte sets that channel's compare enable.
// - a set compare enable turns on the channel comparator against the counter.
// - the cycle length select gives 8, 9, 10 or 11 bit cycles for short pwm channels.
`timescale 1ns/1ps
`include "pcac_consts.vh"

module pcac_array (
   // clock and reset
   input wire clock_i,
   input wire reset_i,
   // register port
   input wire [7:0] sfr_page_i,
   input wire [7:0] sfr_addr_i,
   input wire sfr_wr_i,
   input wire sfr_rd_i,
   input wire [7:0] sfr_wdata_i,
   output wire [7:0] sfr_rdata_o,
   // configuration from the pwm and mode registers
   input wire reload_access_select_i,
   input wire [1:0] cycle_length_select_i,
   input wire [5:0] pwm_short_i,
   input wire [5:0] cmp_en_load_i,
   input wire [5:0] cmp_en_val_i,
   // counter control and capture events
   input wire count_en_i,
   input wire [5:0] capture_i,
   // state out
   output wire [15:0] counter_o,
   output wire cycle_ovf_o,
   output wire [95:0] capture_value_o,
   output wire [95:0] reload_value_o,
   output wire [5:0] compare_enable_o,
   output wire [5:0] match_o
);

// address of a channel low byte by index
function [7:0] lo_addr;
   input integer idx;
   begin
      case (idx)
         0: lo_addr = `PCAC_ADDR_CPL6;
         1: lo_addr = `PCAC_ADDR_CPL7;
         2: lo_addr = `PCAC_ADDR_CPL8;
         3: lo_addr = `PCAC_ADDR_CPL9;
         4: lo_addr = `PCAC_ADDR_CPL10;
         default: lo_addr = `PCAC_ADDR_CPL11;
      endcase
   end
endfunction

// address of a channel high byte by index
function [7:0] hi_addr;
   input integer idx;
   begin
      case (idx)
         0: hi_addr = `PCAC_ADDR_CPH6;
         1: hi_addr = `PCAC_ADDR_CPH7;
         2: hi_addr = `PCAC_ADDR_CPH8;
         3: hi_addr = `PCAC_ADDR_CPH9;
         4: hi_addr = `PCAC_ADDR_CPH10;
         default: hi_addr = `PCAC_ADDR_CPH11;
      endcase
   end
endfunction

// state
reg [15:0] counter_r;
reg [15:0] counter_nxt;
reg [7:0] snapshot_r;
reg [7:0] rdata_r;
reg [7:0] rdata_nxt;
reg cycle_ovf_r;
reg [15:0] len_mask;

// decode
wire page_hit;
wire cnt_lo_hit;
wire cnt_hi_hit;
wire [5:0] ch_lo_hit;
wire [5:0] ch_hi_hit;
wire [47:0] ch_rdata;
wire ovf_now;

// outputs from flops
assign sfr_rdata_o = rdata_r;
assign counter_o = counter_r;
assign cycle_ovf_o = cycle_ovf_r;

// page and counter byte decode
assign page_hit = (sfr_page_i == `PCAC_PAGE);
assign cnt_lo_hit = page_hit && (sfr_addr_i == `PCAC_ADDR_CNT_LO);
assign cnt_hi_hit = page_hit && (sfr_addr_i == `PCAC_ADDR_CNT_HI);

// cycle length mask for short pwm channels
always @* begin
   case (cycle_length_select_i)
      `PCAC_CLSEL_8: len_mask = `PCAC_MASK_8;
      `PCAC_CLSEL_9: len_mask = `PCAC_MASK_9;
      `PCAC_CLSEL_10: len_mask = `PCAC_MASK_10;
      default: len_mask = `PCAC_MASK_11;
   endcase
end

// wrap of the selected low bits while counting
assign ovf_now = count_en_i && !(sfr_wr_i && (cnt_lo_hit || cnt_hi_hit)) &&
   ((counter_r & len_mask) == len_mask);

// counter next value: byte writes win over counting
always @* begin
   counter_nxt = counter_r;
   if (sfr_wr_i && cnt_lo_hit) begin
      counter_nxt[7:0] = sfr_wdata_i;
   end else if (sfr_wr_i && cnt_hi_hit) begin
      counter_nxt[15:8] = sfr_wdata_i;
   end else if (count_en_i) begin
      counter_nxt = counter_r + 16'h0001;
   end
end

// counter register
always @(posedge clock_i or posedge reset_i) begin
   if (reset_i) begin
      counter_r <= `PCAC_RST_WORD;
   end else begin
      counter_r <= counter_nxt;
   end
end

// high byte snapshot, refreshed on low byte reads only
always @(posedge clock_i or posedge reset_i) begin
   if (reset_i) begin
      snapshot_r <= `PCAC_RST_BYTE;
   end else if (sfr_rd_i && cnt_lo_hit) begin
      snapshot_r <= counter_r[15:8];
   end
end

// cycle overflow pulse
always @(posedge clock_i or posedge reset_i) begin
   if (reset_i) begin
      cycle_ovf_r <= `PCAC_RST_BIT;
   end else begin
      cycle_ovf_r <= ovf_now;
   end
end

// per-channel decode and channel instances
genvar g;
generate
   for (g = 0; g < `PCAC_NUM_CH; g = g + 1) begin : ch
      wire [15:0] cap;
      wire [15:0] rel;
      assign ch_lo_hit[g] = page_hit && (sfr_addr_i == lo_addr(g));
      assign ch_hi_hit[g] = page_hit && (sfr_addr_i == hi_addr(g));
      // read data of this channel, zero when not addressed
      assign ch_rdata[g*8 +: 8] =
         ch_lo_hit[g] ? (reload_access_select_i ? rel[7:0] : cap[7:0]) :
         ch_hi_hit[g] ? (reload_access_select_i ? rel[15:8] : cap[15:8]) :
         `PCAC_UNMAPPED;
      assign capture_value_o[g*16 +: 16] = cap;
      assign reload_value_o[g*16 +: 16] = rel;
      pcac_channel u_chan (
         .clock_i(clock_i),
         .reset_i(reset_i),
         .wr_low_i(sfr_wr_i && ch_lo_hit[g]),
         .wr_high_i(sfr_wr_i && ch_hi_hit[g]),
         .reload_sel_i(reload_access_select_i),
         .wdata_i(sfr_wdata_i),
         .cmp_en_load_i(cmp_en_load_i[g]),
         .cmp_en_val_i(cmp_en_val_i[g]),
         .capture_i(capture_i[g]),
         .pwm_short_i(pwm_short_i[g]),
         .cycle_ovf_i(ovf_now),
         .count_i(counter_r),
         .len_mask_i(len_mask),
         .capture_value_o(cap),
         .reload_value_o(rel),
         .compare_enable_o(compare_enable_o[g]),
         .match_o(match_o[g])
      );
   end
endgenerate

// read data mux, unmapped addresses read zero
integer i;
always @* begin
   rdata_nxt = `PCAC_UNMAPPED;
   if (cnt_lo_hit) begin
      rdata_nxt = counter_r[7:0];
   end else if (cnt_hi_hit) begin
      rdata_nxt = snapshot_r;
   end else begin
      for (i = 0; i < `PCAC_NUM_CH; i = i + 1) begin
         rdata_nxt = rdata_nxt | ch_rdata[i*8 +: 8];
      end
   end
end

// read data register, updated on each read strobe
always @(posedge clock_i or posedge reset_i) begin
   if (reset_i) begin
      rdata_r <= `PCAC_RST_BYTE;
   end else if (sfr_rd_i) begin
      rdata_r <= rdata_nxt;
   end
end

endmodule // pcac_array

// [design/pcac_channel.v]
// one capture/compare channel: capture value, reload value, compare enable, match
`timescale 1ns/1ps
`include "pcac_consts.vh"

module pcac_channel (
   // clock and reset
   input wire clock_i,
   input wire reset_i,
   // register writes
   input wire wr_low_i,
   input wire wr_high_i,
   input wire reload_sel_i,
   input wire [7:0] wdata_i,
   // compare enable load from the mode register
   input wire cmp_en_load_i,
   input wire cmp_en_val_i,
   // counter side
   input wire capture_i,
   input wire pwm_short_i,
   input wire cycle_ovf_i,
   input wire [15:0] count_i,
   input wire [15:0] len_mask_i,
   // state out
   output reg [15:0] capture_value_o,
   output reg [15:0] reload_value_o,
   output reg compare_enable_o,
   output reg match_o
);

wire [15:0] cmp_mask;
assign cmp_mask = pwm_short_i ? len_mask_i : `PCAC_MASK_FULL;

// capture value and auto-reload value storage
always @(posedge clock_i or posedge reset_i) begin
   if (reset_i) begin
      capture_value_o <= `PCAC_RST_WORD;
      reload_value_o <= `PCAC_RST_WORD;
   end else begin
      if (wr_low_i && reload_sel_i) begin
         reload_value_o[7:0] <= wdata_i;
      end else if (wr_high_i && reload_sel_i) begin
         reload_value_o[15:8] <= wdata_i;
      end
      if (wr_low_i && !reload_sel_i) begin
         capture_value_o[7:0] <= wdata_i;
      end else if (wr_high_i && !reload_sel_i) begin
         capture_value_o[15:8] <= wdata_i;
      end else if (capture_i) begin
         capture_value_o <= count_i;
      end else if (cycle_ovf_i && pwm_short_i) begin
         capture_value_o <= reload_value_o;
      end
   end
end

// compare enable with write side effects
always @(posedge clock_i or posedge reset_i) begin
   if (reset_i) begin
      compare_enable_o <= `PCAC_RST_BIT;
   end else if (wr_high_i) begin
      compare_enable_o <= 1'b1;
   end else if (wr_low_i) begin
      compare_enable_o <= 1'b0;
   end else if (cmp_en_load_i) begin
      compare_enable_o <= cmp_en_val_i;
   end
end

// comparator against the array counter
always @(posedge clock_i or posedge reset_i) begin
   if (reset_i) begin
      match_o <= `PCAC_RST_BIT;
   end else begin
      match_o <= compare_enable_o &&
         ((count_i & cmp_mask) == (capture_value_o & cmp_mask));
   end
end

endmodule // pcac_channel

// [design/pcac_consts.vh]
// register addresses, reset values and cycle-length constants of the counter array
`ifndef PCAC_CONSTS_VH
`define PCAC_CONSTS_VH

// register page shared by every register of the block
`define PCAC_PAGE 8'h10

// counter byte registers
`define PCAC_ADDR_CNT_LO 8'hf9
`define PCAC_ADDR_CNT_HI 8'hfa

// capture low-byte registers, channels 6 to 11
`define PCAC_ADDR_CPL6 8'hfb
`define PCAC_ADDR_CPL7 8'he9
`define PCAC_ADDR_CPL8 8'heb
`define PCAC_ADDR_CPL9 8'hed
`define PCAC_ADDR_CPL10 8'hfd
`define PCAC_ADDR_CPL11 8'hce

// capture high-byte registers, channels 6 to 11
`define PCAC_ADDR_CPH6 8'hfc
`define PCAC_ADDR_CPH7 8'hea
`define PCAC_ADDR_CPH8 8'hec
`define PCAC_ADDR_CPH9 8'hee
`define PCAC_ADDR_CPH10 8'hfe
`define PCAC_ADDR_CPH11 8'hcf

// sizes
`define PCAC_NUM_CH 6
`define PCAC_CW 16

// reset values
`define PCAC_RST_BYTE 8'h00
`define PCAC_RST_WORD 16'h0000
`define PCAC_RST_BIT 1'b0
`define PCAC_UNMAPPED 8'h00

// cycle length select codes
`define PCAC_CLSEL_8 2'b00
`define PCAC_CLSEL_9 2'b01
`define PCAC_CLSEL_10 2'b10
`define PCAC_CLSEL_11 2'b11

// counter masks for each cycle length
`define PCAC_MASK_8 16'h00ff
`define PCAC_MASK_9 16'h01ff
`define PCAC_MASK_10 16'h03ff
`define PCAC_MASK_11 16'h07ff
`define PCAC_MASK_FULL 16'hffff

`endif

// [testbench/pca_counter_capture_regs_test.sv]
// self-checking bench for the counter array
`timescale 1ns/1ps
`include "pcac_consts.vh"
module pca_counter_capture_regs_test;
   logic clock_i = 0, reset_i = 1, wr = 0, rd = 0, ras = 0, cen = 0;
   logic [7:0] pg = 8'h10, ad = 8'h00, wd = 8'h00, rd_v;
   logic [1:0] cls = 2'b00;
   logic [5:0] psh = 0, cel = 0, cev = 0, cap = 0, ce, mt;
   logic [7:0] rdat;
   logic ovf;
   logic [15:0] cnt;
   logic [95:0] capv, relv;
   int fail_count = 0, check_count = 0, cyc = 0;
   logic [7:0] lo_a [6] = '{8'hfb, 8'he9, 8'heb, 8'hed, 8'hfd, 8'hce};
   logic [7:0] hi_a [6] = '{8'hfc, 8'hea, 8'hec, 8'hee, 8'hfe, 8'hcf};
   pcac_array i_dut (.clock_i(clock_i), .reset_i(reset_i), .sfr_page_i(pg), .sfr_addr_i(ad),
      .sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_wdata_i(wd), .sfr_rdata_o(rdat),
      .reload_access_select_i(ras), .cycle_length_select_i(cls), .pwm_short_i(psh),
      .cmp_en_load_i(cel), .cmp_en_val_i(cev), .count_en_i(cen), .capture_i(cap),
      .counter_o(cnt), .cycle_ovf_o(ovf), .capture_value_o(capv), .reload_value_o(relv),
      .compare_enable_o(ce), .match_o(mt));
   // clock and hang guard
   initial forever #20 clock_i = ~clock_i;
   always @(posedge clock_i) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         fail_count++;
         $display("ERROR %0t: timeout", $time);
         end_sim;
      end
   end
   task end_sim;
      begin
         $display("checks %0d mismatches %0d", check_count, fail_count);
         if (fail_count == 0 && check_count > 0) $display("== PASSED ==");
         else $display("== FAILED ==");
         $finish;
      end
   endtask
   task chk(input [95:0] got, input [95:0] exp);
      begin
         check_count++;
         if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   // one access, strobe held for one edge, read data taken after it
   task acc(input w, input [7:0] a, input [7:0] d);
      begin
         @(posedge clock_i);
         #1;
         wr = w;
         rd = !w;
         ad = a;
         wd = d;
         @(posedge clock_i);
         #1;
         wr = 0;
         rd = 0;
         rd_v = rdat;
      end
   endtask
   task tick;
      begin
         @(posedge clock_i);
         #1;
      end
   endtask
   task t_reset;
      begin
         chk({cnt, ce}, 0);
         chk(capv, 0);
         for (int i = 0; i < 6; i++) begin
            acc(0, lo_a[i], 0);
            chk(rd_v, 0);
            acc(0, hi_a[i], 0);
            chk(rd_v, 0);
         end
         $display("t_reset done");
      end
   endtask
   task t_map;
      logic [95:0] e;
      begin
         e = 0;
         for (int i = 0; i < 6; i++) begin
            acc(1, hi_a[i], 8'h60 + i[7:0]);
            chk(ce[i], 1);
            acc(1, lo_a[i], 8'h90 + i[7:0]);
            chk(ce[i], 0);
            e[i*16 +: 16] = {8'h60 + i[7:0], 8'h90 + i[7:0]};
            acc(0, hi_a[i], 0);
            chk(rd_v, 8'h60 + i[7:0]);
            acc(0, lo_a[i], 0);
            chk(rd_v, 8'h90 + i[7:0]);
         end
         chk(capv, e);
         $display("t_map done");
      end
   endtask
   task t_cnt;
      begin
         acc(1, 8'hfa, 8'h12);
         acc(1, 8'hf9, 8'hfe);
         chk(cnt, 16'h12fe);
         acc(0, 8'hfa, 0);
         chk(rd_v, 0);
         cen = 1;
         acc(0, 8'hf9, 0);
         chk(rd_v, 8'hff);
         chk(ovf, 1);
         acc(0, 8'hfa, 0);
         chk(rd_v, 8'h12);
         chk(ovf, 0);
         cen = 0;
         chk(cnt, 16'h1302);
         acc(0, 8'hf9, 0);
         acc(1, 8'hfa, 8'h12);
         acc(0, 8'hfa, 0);
         chk(rd_v, 8'h13);
         acc(1, 8'hf9, 8'h34);
         chk(cnt, 16'h1234);
         $display("t_cnt done");
      end
   endtask
   task t_rel;
      begin
         ras = 1;
         acc(1, 8'hfb, 8'ha5);
         acc(1, 8'hfc, 8'h5a);
         chk({relv[15:0], capv[15:0]}, 32'h5aa5_6090);
         acc(0, 8'hfb, 0);
         chk(rd_v, 8'ha5);
         ras = 0;
         acc(0, 8'hfb, 0);
         chk(rd_v, 8'h90);
         $display("t_rel done");
      end
   endtask
   task t_match;
      begin
         acc(1, 8'hfb, 8'h34);
         acc(1, 8'hfc, 8'h16);
         tick;
         chk(mt[0], 0);
         psh = 6'h01;
         for (int c = 0; c < 4; c++) begin
            cls = c[1:0];
            tick;
            chk(mt[0], c != 3);
         end
         psh = 0;
         acc(1, 8'hfc, 8'h12);
         tick;
         chk(mt[0], 1);
         acc(1, 8'hfb, 8'h34);
         tick;
         chk(mt[0], 0);
         $display("t_match done");
      end
   endtask
   task t_evt;
      begin
         cap = 6'h02;
         tick;
         cap = 0;
         chk(capv[31:16], 16'h1234);
         cev = 6'h02;
         cel = 6'h02;
         tick;
         cel = 0;
         chk(ce[1], 1);
         pg = 8'h0f;
         acc(1, 8'he9, 8'hff);
         chk(capv[31:16], 16'h1234);
         acc(0, 8'he9, 0);
         chk(rd_v, 0);
         pg = 8'h10;
         acc(0, 8'h00, 0);
         chk(rd_v, 0);
         $display("t_evt done");
      end
   endtask
   // reset, then the scenarios in turn
   initial begin
      repeat (16) @(posedge clock_i);
      #1;
      reset_i = 0;
      t_reset;
      t_map;
      t_cnt;
      t_rel;
      t_match;
      t_evt;
      end_sim;
   end
endmodule // pca_counter_capture_regs_test

// [testbench/pcac_array_checker.sv]
// concurrent checks on the counter array register port
`timescale 1ns/1ps
module pcac_array_checker (
   // clock and reset
   input wire clock_i,
   input wire reset_i,
   // register port
   input wire [7:0] sfr_page_i,
   input wire [7:0] sfr_addr_i,
   input wire sfr_wr_i,
   input wire sfr_rd_i,
   input wire [7:0] sfr_wdata_i,
   input wire [7:0] sfr_rdata_o,
   // configuration and state
   input wire reload_access_select_i,
   input wire [1:0] cycle_length_select_i,
   input wire [5:0] pwm_short_i,
   input wire count_en_i,
   input wire [15:0] counter_o,
   input wire cycle_ovf_o,
   input wire [95:0] capture_value_o,
   input wire [95:0] reload_value_o,
   input wire [5:0] compare_enable_o,
   input wire [5:0] match_o
);
   // decoded strobes on the block's own page
   wire pg_ok = (sfr_page_i == 8'h10);
   wire rd_ok = sfr_rd_i && pg_ok;
   wire wr_ok = sfr_wr_i && pg_ok;
   reg [7:0] snap_r;
   // expected snapshot, refreshed only by low counter reads
   always @(posedge clock_i or posedge reset_i) begin
      if (reset_i) snap_r <= 8'h00;
      else if (rd_ok && sfr_addr_i == 8'hf9) snap_r <= counter_o[15:8];
   end
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (reset_i);
   a_cnt_lo_read: assert property (rd_ok && sfr_addr_i == 8'hf9 |=>
      sfr_rdata_o == $past(counter_o[7:0])) else $error("low counter read wrong");
   a_cnt_hi_snap: assert property (rd_ok && sfr_addr_i == 8'hfa |=>
      sfr_rdata_o == $past(snap_r)) else $error("high counter read not snapshot");
   a_cnt_lo_wr: assert property (wr_ok && sfr_addr_i == 8'hf9 |=>
      counter_o == {$past(counter_o[15:8]), $past(sfr_wdata_i)}) else $error("counter load wrong");
   a_cap_lo_wr: assert property (wr_ok && sfr_addr_i == 8'hfb && !reload_access_select_i |=>
      capture_value_o[7:0] == $past(sfr_wdata_i) && !compare_enable_o[0]) else $error("cap low");
   a_cap_hi_wr: assert property (wr_ok && sfr_addr_i == 8'hcf && !reload_access_select_i |=>
      capture_value_o[95:88] == $past(sfr_wdata_i) && compare_enable_o[5]) else $error("cap high");
   a_reload_lo_wr: assert property (wr_ok && sfr_addr_i == 8'hfb && reload_access_select_i |=>
      reload_value_o[7:0] == $past(sfr_wdata_i) && !compare_enable_o[0]) else $error("reload low");
   a_match_full: assert property (!pwm_short_i[0] |=> match_o[0] ==
      $past(compare_enable_o[0] && counter_o == capture_value_o[15:0])) else $error("match");
   a_ovf_pulse: assert property (count_en_i && !sfr_wr_i && cycle_length_select_i == 2'b00 &&
      counter_o[7:0] == 8'hff |=> cycle_ovf_o) else $error("cycle overflow missing");
endmodule // pcac_array_checker

bind pcac_array pcac_array_checker i_chk (.clock_i(clock_i), .reset_i(reset_i),
   .sfr_page_i(sfr_page_i), .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i),
   .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o),
   .reload_access_select_i(reload_access_select_i),
   .cycle_length_select_i(cycle_length_select_i), .pwm_short_i(pwm_short_i),
   .count_en_i(count_en_i), .counter_o(counter_o), .cycle_ovf_o(cycle_ovf_o),
   .capture_value_o(capture_value_o), .reload_value_o(reload_value_o),
   .compare_enable_o(compare_enable_o), .match_o(match_o));
